//--- src/gdo_regs.sv
// module: drive-enable and drive-level registers of one eight-pin port, axi4-lite slave
//
// Function
// [R1] drive-enable bit one makes pin output
// [R2] drive-enable never touches the input buffer
// [R3] set strobe: ones set drive-enable bits
// [R4] clear strobe: ones clear drive-enable bits
// [R5] toggle strobe: ones invert drive-enable bits
// [R6] enable strobe reads return drive-enable
// [R7] drive-level bit one drives pin high
// [R8] level drives only while enable set
// [R9] high strobe: ones set level bits
// [R10] low strobe: ones clear level bits
// [R11] level strobe reads return drive-level
// [R12] strobe updates written ones, next cycle
`timescale 1ns/10ps
`default_nettype none
module gdo_regs (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite write address
    input wire logic [gdo_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [gdo_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    gdo_pkg::gdo_drive_t drive_reg;
    logic [gdo_pkg::ADDR_WIDTH-1:0] awaddr_reg;
    logic aw_held_reg;
    logic [7:0] wdata_reg;
    logic w_lane0_reg;
    logic w_held_reg;
    logic [7:0] pin_s1_reg;
    logic [7:0] pin_s2_reg;
    logic [7:0] pin_s3_reg;
    logic [7:0] pin_state_reg;
    logic do_write;
    logic [2:0] widx;
    logic [2:0] ridx;
    logic [7:0] rbyte;

    // one write and one read at a time; address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = clk_en && aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign widx = awaddr_reg[gdo_pkg::IDX_MSB:gdo_pkg::IDX_LSB];
    assign ridx = s_axi_araddr[gdo_pkg::IDX_MSB:gdo_pkg::IDX_LSB];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            else if (do_write)
            begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gdo_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                // the pin state word is read-only
                s_axi_bresp <= (widx == gdo_pkg::IDX_PIN_STATE) ? gdo_pkg::RESP_SLVERR
                    : gdo_pkg::RESP_OKAY;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // [R12] strobes change written ones only, next edge; plain writes load the whole byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drive_reg.enable <= gdo_pkg::DRIVE_ENABLE_RESET;
            drive_reg.level <= gdo_pkg::DRIVE_LEVEL_RESET;
        end
        else if (do_write && w_lane0_reg)
        begin
            unique case (widx)
                gdo_pkg::IDX_DRIVE_ENABLE: drive_reg.enable <= wdata_reg;
                // [R3] set enable bits
                gdo_pkg::IDX_DRIVE_ENABLE_SET: drive_reg.enable <= drive_reg.enable | wdata_reg;
                // [R4] clear enable bits
                gdo_pkg::IDX_DRIVE_ENABLE_CLEAR:
                    drive_reg.enable <= drive_reg.enable & ~wdata_reg;
                // [R5] invert enable bits
                gdo_pkg::IDX_DRIVE_ENABLE_TOGGLE:
                    drive_reg.enable <= drive_reg.enable ^ wdata_reg;
                gdo_pkg::IDX_DRIVE_LEVEL: drive_reg.level <= wdata_reg;
                // [R9] set level bits
                gdo_pkg::IDX_DRIVE_LEVEL_SET: drive_reg.level <= drive_reg.level | wdata_reg;
                // [R10] clear level bits
                gdo_pkg::IDX_DRIVE_LEVEL_CLEAR: drive_reg.level <= drive_reg.level & ~wdata_reg;
                gdo_pkg::IDX_PIN_STATE: drive_reg <= drive_reg;
            endcase
        end
    end

    // [R2] input path ignores drive enable
    // pin levels come from outside: three stages, change taken once stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_reg <= 8'h00;
            pin_s2_reg <= 8'h00;
            pin_s3_reg <= 8'h00;
            pin_state_reg <= 8'h00;
        end
        else if (clk_en)
        begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            for (int i = 0; i < gdo_pkg::PIN_COUNT; i++)
            begin
                if (pin_s2_reg[i] == pin_s3_reg[i])
                begin
                    pin_state_reg[i] <= pin_s3_reg[i];
                end
            end
        end
    end

    always_comb
    begin
        rbyte = 8'h00;
        unique case (ridx)
            // [R6] enable strobes read enable
            gdo_pkg::IDX_DRIVE_ENABLE, gdo_pkg::IDX_DRIVE_ENABLE_SET,
            gdo_pkg::IDX_DRIVE_ENABLE_CLEAR, gdo_pkg::IDX_DRIVE_ENABLE_TOGGLE:
                rbyte = drive_reg.enable;
            // [R11] level strobes read level
            gdo_pkg::IDX_DRIVE_LEVEL, gdo_pkg::IDX_DRIVE_LEVEL_SET,
            gdo_pkg::IDX_DRIVE_LEVEL_CLEAR:
                rbyte = drive_reg.level;
            gdo_pkg::IDX_PIN_STATE: rbyte = pin_state_reg;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gdo_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rbyte};
                s_axi_rresp <= gdo_pkg::RESP_OKAY;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // [R1] enable bit drives the pin
    assign pin_oe = drive_reg.enable;
    // [R7] level bit high or low; [R8] gated by enable
    assign pin_out = drive_reg.level & drive_reg.enable;
endmodule : gdo_regs
`default_nettype wire

//--- src/gdo_pkg.sv
// package: register map, field layout and bus types of the gpio drive block
package gdo_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_WIDTH = 5;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [2:0] IDX_DRIVE_ENABLE = 3'h0;
    localparam logic [2:0] IDX_DRIVE_ENABLE_SET = 3'h1;
    localparam logic [2:0] IDX_DRIVE_ENABLE_CLEAR = 3'h2;
    localparam logic [2:0] IDX_DRIVE_ENABLE_TOGGLE = 3'h3;
    localparam logic [2:0] IDX_DRIVE_LEVEL = 3'h4;
    localparam logic [2:0] IDX_DRIVE_LEVEL_SET = 3'h5;
    localparam logic [2:0] IDX_DRIVE_LEVEL_CLEAR = 3'h6;
    localparam logic [2:0] IDX_PIN_STATE = 3'h7;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 4;
    localparam logic [7:0] DRIVE_ENABLE_RESET = 8'h00;
    localparam logic [7:0] DRIVE_LEVEL_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] level;
    } gdo_drive_t;
endpackage : gdo_pkg

//--- verif/gdo_regs_asserts.sv
// checker: bus and pin assertions for gdo_regs
`timescale 1ns/10ps
`default_nettype none
module gdo_regs_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_gate; (pin_out & ~pin_oe) == 8'h0; endproperty
    a_gate: assert property (p_gate) else $error("idle pin driven high");
    property p_oe; $changed(pin_oe) |-> $rose(s_axi_bvalid); endproperty
    a_oe: assert property (p_oe) else $error("enable moved without write");
    property p_out; $changed(pin_out) |-> $rose(s_axi_bvalid); endproperty
    a_out: assert property (p_out) else $error("level moved without write");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("write answer stuck");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer not held");
    property p_rtop; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rtop: assert property (p_rtop) else $error("read upper bits set");
    property p_awblk; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_awblk: assert property (p_awblk) else $error("second write accepted");
endmodule : gdo_regs_asserts
bind gdo_regs gdo_regs_asserts u_chk (.*);
`default_nettype wire

//--- verif/tb_gdo_regs.sv
// testbench: random and corner register traffic for gdo_regs
`timescale 1ns/10ps
`default_nettype none
module tb_gdo_regs;
    logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [gdo_pkg::ADDR_WIDTH-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, cyc;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] pin_in, pin_out, pin_oe, en, lv;
    int fail_count, n_tests;
    gdo_regs dut (.*);
    always #20 aclk = ~aclk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic void upd(input logic [2:0] i, input logic [7:0] d);
        case (i)
            3'h0: en = d;
            3'h1: en = en | d;
            3'h2: en = en & ~d;
            3'h3: en = en ^ d;
            3'h4: lv = d;
            3'h5: lv = lv | d;
            3'h6: lv = lv & ~d;
            default: ;
        endcase
    endfunction : upd
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic wr(input logic [2:0] i, input logic [7:0] d, input logic s, output logic [1:0] r);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= {3'h0, s};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        // late ready stalls the answer a cycle
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [2:0] i, output logic [31:0] d);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, gdo_pkg::RESP_OKAY});
        d = s_axi_rdata;
    endtask : rd
    task automatic step(input logic [2:0] i, input logic [7:0] d, input logic s);
        logic [1:0] r;
        logic [31:0] q;
        wr(i, d, s, r);
        if (s)
            upd(i, d);
        q = {30'h0, (i == 3'h7) ? gdo_pkg::RESP_SLVERR : gdo_pkg::RESP_OKAY};
        chk("bresp", {30'h0, r}, q);
        chk("pin_oe", {24'h0, pin_oe}, {24'h0, en});
        chk("pin_out", {24'h0, pin_out}, {24'h0, lv & en});
        for (int j = 0; j < 8; j++)
        begin
            rd(j[2:0], q);
            chk("rdata", q, {24'h0, (j == 7) ? pin_in : (j < 4) ? en : lv});
        end
    endtask : step
    always @(posedge aclk)
    begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h4e20)
        begin
            fail_count++;
            summarize();
        end
    end
    initial
    begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
        {clk_en, pin_in, en, lv, cyc, seed} = {1'b1, 24'h0, 32'h0, 32'h2521};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // zero set first: reads show reset values
        step(3'h1, 8'h00, 1'b1);
        step(3'h3, 8'hff, 1'b1);
        step(3'h7, 8'hff, 1'b1);
        step(3'h0, 8'h5a, 1'b0);
        repeat (60)
        begin
            seed = xs(seed);
            pin_in <= seed[31:24];
            step(seed[2:0], seed[15:8], seed[20:18] != 3'h0 || seed[2:0] == 3'h7);
        end
        summarize();
    end
endmodule : tb_gdo_regs
`default_nettype wire
